// ==== common/pscr_regs.vh ====
// Purpose: register map and timing constants of the phase shed config bank
// Assumes: 8-bit register port, 50 MHz clock
// Notes: definitions only
`ifndef PSCR_REGS_VH
`define PSCR_REGS_VH

// register offsets
`define PSCR_OFF_THR_CFG_1 8'h3a
`define PSCR_OFF_THR_STAT_1 8'h3b
`define PSCR_OFF_THR_CFG_2 8'h3c
`define PSCR_OFF_THR_STAT_2 8'h3d
`define PSCR_OFF_THR_CFG_3 8'h3e
`define PSCR_OFF_THR_STAT_3 8'h3f
`define PSCR_OFF_THR_CFG_4 8'h40
`define PSCR_OFF_THR_STAT_4 8'h41
`define PSCR_OFF_HYST 8'h44
`define PSCR_OFF_DELAY 8'h45
`define PSCR_OFF_LATCH_A 8'h46
`define PSCR_OFF_LATCH_B 8'h47

// latch field positions
`define PSCR_BIT_SWITCHING 5
`define PSCR_BIT_DROOP 4
`define PSCR_BIT_OVERCURRENT 2
`define PSCR_BIT_THRESHOLD 0
`define PSCR_LATCH_MASK 8'h35

// special codes and reset values
`define PSCR_THR_DISABLED 8'hff
`define PSCR_RST_THR_CFG 8'hff
`define PSCR_RST_THR_STAT 8'hff // no strap reading yet, so disabled
`define PSCR_RST_HYST 8'h00
`define PSCR_RST_LATCH 8'h00
`define PSCR_UNMAPPED_READ 8'h00

// timing: delay register step and power-up delay
`define PSCR_CLK_NS 20
`define PSCR_DELAY_STEP_US 10
`define PSCR_DELAY_RST_US 200
`define PSCR_DELAY_STEP_CYC ((`PSCR_DELAY_STEP_US * 1000) / `PSCR_CLK_NS)
// power-up delay of 200 us in 10 us steps, sized for the 8-bit register
`define PSCR_RST_DELAY 8'h14

// droop line fractions in percent
`define PSCR_DROOP_FULL 7'd100
`define PSCR_DROOP_HALF 7'd50
`define PSCR_DROOP_QUARTER 7'd25
`define PSCR_DROOP_ZERO 7'd0

`endif

// ==== rtl/pscr_thresh_unit.v ====
// Purpose: one shedding threshold with hysteresis and drop delay
// Assumes: tick is a one-cycle pulse per delay step
// Notes: above rises at once, falls after the programmed delay, or at once when the threshold is disabled
`timescale 1ns/10ps
`default_nettype none

module pscr_thresh_unit #(
	parameter W = 8
)(
	input wire clk,
	input wire sys_rst,
	input wire tick,
	input wire [W-1:0] current,
	input wire [W-1:0] thr,
	input wire [W-1:0] hyst,
	input wire [W-1:0] delay,
	output reg above
);

	reg [W-1:0] wait_cnt; // elapsed delay steps while below the low edge
	wire disabled; // all-ones threshold switches this unit off
	wire up; // at or above the threshold
	wire down; // below threshold minus hysteresis

	assign disabled = (thr == {W{1'b1}});
	assign up = (current >= thr);
	// one extra bit so a large hysteresis cannot wrap
	assign down = ({1'b0, current} + {1'b0, hyst}) < {1'b0, thr};

	// raise immediately, lower after the delay has run out, or at once when disabled
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			above <= 1'b0;
			wait_cnt <= {W{1'b0}};
		end
		else if (disabled)
		begin
			// disabled threshold never asks for the extra phase
			above <= 1'b0;
			wait_cnt <= {W{1'b0}};
		end
		else if (!above)
		begin
			// rising direction ignores hysteresis and delay
			above <= up;
			wait_cnt <= {W{1'b0}};
		end
		else if (down)
		begin
			// falling direction: hysteresis applied, then wait
			if (wait_cnt >= delay)
			begin
				above <= 1'b0;
				wait_cnt <= {W{1'b0}};
			end
			else if (tick)
				wait_cnt <= wait_cnt + {{(W-1){1'b0}}, 1'b1};
		end
		else
			wait_cnt <= {W{1'b0}}; // load came back, restart the wait
	end

endmodule

`default_nettype wire

// ==== rtl/pscr_top.v ====
// Purpose: phase shedding configuration register bank
// Assumes: register port driven by an external bus engine, one clock
// Notes: straps arrive already digitised as threshold codes
//
// Behaviour
// - threshold registers used only when both latches select
// - threshold value all-ones disables that threshold
// - status registers reload on enable rising edge
// - strap above two volts disables threshold
// - hysteresis applies only when shedding phases
// - shed delay 200us default, 10us steps
// - enable toggle returns all functions to straps
// - source changes after identical byte in both
// - latch bit 5 selects switching rate source
// - latch bit 4 selects droop line source
// - latch bit 2 selects overcurrent limit source
// - latch bit 0 selects threshold register source
// - droop code: full, half, quarter, zero
`timescale 1ns/10ps
`default_nettype none
`include "pscr_regs.vh"

module pscr_top #(
	parameter W = 8,
	parameter N_THR = 4,
	parameter STEP_CYC = `PSCR_DELAY_STEP_CYC
)(
	input wire clk,
	input wire sys_rst,
	// enable input of the controller
	input wire en_pin,
	// register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// digitised strap levels, one code per threshold pin
	input wire [4*W-1:0] strap_code,
	// strap sensed above two volts, one bit per pin
	input wire [3:0] strap_over_2v,
	// live output current reading code
	input wire [W-1:0] output_current_reading,
	// droop code from its config register and from its strap
	input wire [1:0] droop_reg_code,
	input wire [1:0] droop_strap_code,
	// selected sources
	output reg switching_rate_source,
	output reg droop_line_source,
	output reg overcurrent_limit_source,
	output reg shed_threshold_source,
	// resulting droop fraction in percent
	output reg [6:0] droop_fraction_pct,
	// number of active phases, 1 to 4
	output reg [2:0] phase_count
);

	// configuration registers (read-write)
	reg [W-1:0] thr_cfg_1;
	reg [W-1:0] thr_cfg_2;
	reg [W-1:0] thr_cfg_3;
	reg [W-1:0] thr_cfg_4;
	reg [W-1:0] shed_hysteresis;
	reg [W-1:0] shed_delay;
	// status registers, loaded only from straps
	reg [W-1:0] thr_stat_1;
	reg [W-1:0] thr_stat_2;
	reg [W-1:0] thr_stat_3;
	reg [W-1:0] thr_stat_4;
	// the two latch halves and the committed selection
	reg [7:0] latch_a;
	reg [7:0] latch_b;
	reg [7:0] source_sel;
	// enable edge detection
	reg en_prev;
	wire en_rise;
	wire en_toggle;
	// delay step divider
	reg [15:0] step_cnt;
	reg step_tick;
	// effective thresholds after source selection
	reg [W-1:0] thr_eff [0:3];
	wire [3:0] above;
	// write strobes and masked write data
	wire wr_a;
	wire wr_b;
	wire [7:0] wdata_masked;
	// read mux result
	reg [7:0] next_rdata;
	// combinational phase count
	reg [2:0] next_phase_count;
	integer i;

	assign en_rise = en_pin && !en_prev;
	assign en_toggle = en_pin ^ en_prev;
	assign wr_a = reg_wr && (reg_addr == `PSCR_OFF_LATCH_A);
	assign wr_b = reg_wr && (reg_addr == `PSCR_OFF_LATCH_B);
	// reserved bits never get stored
	assign wdata_masked = reg_wdata & `PSCR_LATCH_MASK;

	// remember the last enable level
	always @(posedge clk)
	begin
		if (sys_rst)
			en_prev <= 1'b0;
		else
			en_prev <= en_pin;
	end

	// free-running divider for one delay step
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			step_cnt <= 16'h0000;
			step_tick <= 1'b0;
		end
		else if (step_cnt == STEP_CYC - 1)
		begin
			step_cnt <= 16'h0000;
			step_tick <= 1'b1;
		end
		else
		begin
			step_cnt <= step_cnt + 16'h0001;
			step_tick <= 1'b0;
		end
	end

	// host writes to the configuration registers
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			thr_cfg_1 <= `PSCR_RST_THR_CFG;
			thr_cfg_2 <= `PSCR_RST_THR_CFG;
			thr_cfg_3 <= `PSCR_RST_THR_CFG;
			thr_cfg_4 <= `PSCR_RST_THR_CFG;
			shed_hysteresis <= `PSCR_RST_HYST;
			shed_delay <= `PSCR_RST_DELAY;
		end
		else if (reg_wr)
		begin
			// status offsets fall through and are ignored
			case (reg_addr)
				`PSCR_OFF_THR_CFG_1: thr_cfg_1 <= reg_wdata;
				`PSCR_OFF_THR_CFG_2: thr_cfg_2 <= reg_wdata;
				`PSCR_OFF_THR_CFG_3: thr_cfg_3 <= reg_wdata;
				`PSCR_OFF_THR_CFG_4: thr_cfg_4 <= reg_wdata;
				`PSCR_OFF_HYST: shed_hysteresis <= reg_wdata;
				`PSCR_OFF_DELAY: shed_delay <= reg_wdata;
				default: ;
			endcase
		end
	end

	// status copies follow the straps on each enable rising edge
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			thr_stat_1 <= `PSCR_RST_THR_STAT;
			thr_stat_2 <= `PSCR_RST_THR_STAT;
			thr_stat_3 <= `PSCR_RST_THR_STAT;
			thr_stat_4 <= `PSCR_RST_THR_STAT;
		end
		else if (en_rise)
		begin
			// an overvoltage strap is stored as the disable code
			thr_stat_1 <= strap_over_2v[0] ? `PSCR_THR_DISABLED :
				strap_code[W-1:0];
			thr_stat_2 <= strap_over_2v[1] ? `PSCR_THR_DISABLED :
				strap_code[2*W-1:W];
			thr_stat_3 <= strap_over_2v[2] ? `PSCR_THR_DISABLED :
				strap_code[3*W-1:2*W];
			thr_stat_4 <= strap_over_2v[3] ? `PSCR_THR_DISABLED :
				strap_code[4*W-1:3*W];
		end
	end

	// latch pair: selection moves only when both halves agree
	// comparing against the other half's stored value lets either
	// write come first; a write landing with the enable toggle loses
	// because returning to the straps is the safe direction
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			latch_a <= `PSCR_RST_LATCH;
			latch_b <= `PSCR_RST_LATCH;
			source_sel <= `PSCR_RST_LATCH;
		end
		else if (en_toggle)
		begin
			// back to external resistors on any enable edge
			latch_a <= `PSCR_RST_LATCH;
			latch_b <= `PSCR_RST_LATCH;
			source_sel <= `PSCR_RST_LATCH;
		end
		else if (wr_a)
		begin
			latch_a <= wdata_masked;
			if (wdata_masked == latch_b)
				source_sel <= wdata_masked;
			// mismatch keeps the old selection
		end
		else if (wr_b)
		begin
			latch_b <= wdata_masked;
			if (wdata_masked == latch_a)
				source_sel <= wdata_masked;
		end
	end

	// pick the threshold set in force
	always @*
	begin
		if (source_sel[`PSCR_BIT_THRESHOLD])
		begin
			// register values once both halves have selected them
			thr_eff[0] = thr_cfg_1;
			thr_eff[1] = thr_cfg_2;
			thr_eff[2] = thr_cfg_3;
			thr_eff[3] = thr_cfg_4;
		end
		else
		begin
			// strap-derived values otherwise
			thr_eff[0] = thr_stat_1;
			thr_eff[1] = thr_stat_2;
			thr_eff[2] = thr_stat_3;
			thr_eff[3] = thr_stat_4;
		end
	end

	// one comparator with hysteresis and delay per threshold
	genvar g;
	generate
		for (g = 0; g < N_THR; g = g + 1)
		begin : gen_thr
			pscr_thresh_unit #(
				.W(W)
			) u_thr (
				.clk(clk),
				.sys_rst(sys_rst),
				.tick(step_tick),
				.current(output_current_reading),
				.thr(thr_eff[g]),
				.hyst(shed_hysteresis),
				.delay(shed_delay),
				.above(above[g])
			);
		end
	endgenerate

	// one phase always runs, each crossed threshold adds one; the sum
	// saturates at four because there are no more phases to turn on
	always @*
	begin
		next_phase_count = 3'd1;
		for (i = 0; i < N_THR; i = i + 1)
		begin
			if (above[i] && (next_phase_count < 3'd4))
				next_phase_count = next_phase_count + 3'd1;
		end
	end

	// register the phase count so the output is glitch free
	always @(posedge clk)
	begin
		if (sys_rst)
			phase_count <= 3'd1;
		else
			phase_count <= next_phase_count;
	end

	// source flags straight from the committed selection
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			switching_rate_source <= 1'b0;
			droop_line_source <= 1'b0;
			overcurrent_limit_source <= 1'b0;
			shed_threshold_source <= 1'b0;
		end
		else
		begin
			switching_rate_source <=
				source_sel[`PSCR_BIT_SWITCHING];
			droop_line_source <= source_sel[`PSCR_BIT_DROOP];
			overcurrent_limit_source <=
				source_sel[`PSCR_BIT_OVERCURRENT];
			shed_threshold_source <=
				source_sel[`PSCR_BIT_THRESHOLD];
		end
	end

	// droop fraction from whichever code is in force
	always @(posedge clk)
	begin
		if (sys_rst)
			droop_fraction_pct <= `PSCR_DROOP_FULL;
		else
		begin
			case (source_sel[`PSCR_BIT_DROOP] ? droop_reg_code :
				droop_strap_code)
				2'b00: droop_fraction_pct <= `PSCR_DROOP_FULL;
				2'b01: droop_fraction_pct <= `PSCR_DROOP_HALF;
				2'b10: droop_fraction_pct <= `PSCR_DROOP_QUARTER;
				2'b11: droop_fraction_pct <= `PSCR_DROOP_ZERO;
				default: droop_fraction_pct <= `PSCR_DROOP_FULL;
			endcase
		end
	end

	// read mux; unmapped offsets read as zero
	always @*
	begin
		case (reg_addr)
			`PSCR_OFF_THR_CFG_1: next_rdata = thr_cfg_1;
			`PSCR_OFF_THR_STAT_1: next_rdata = thr_stat_1;
			`PSCR_OFF_THR_CFG_2: next_rdata = thr_cfg_2;
			`PSCR_OFF_THR_STAT_2: next_rdata = thr_stat_2;
			`PSCR_OFF_THR_CFG_3: next_rdata = thr_cfg_3;
			`PSCR_OFF_THR_STAT_3: next_rdata = thr_stat_3;
			`PSCR_OFF_THR_CFG_4: next_rdata = thr_cfg_4;
			`PSCR_OFF_THR_STAT_4: next_rdata = thr_stat_4;
			`PSCR_OFF_HYST: next_rdata = shed_hysteresis;
			`PSCR_OFF_DELAY: next_rdata = shed_delay;
			// stored halves, reserved bits already zero
			`PSCR_OFF_LATCH_A: next_rdata = latch_a;
			`PSCR_OFF_LATCH_B: next_rdata = latch_b;
			default: next_rdata = `PSCR_UNMAPPED_READ;
		endcase
	end

	// read data held until the next read
	always @(posedge clk)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= next_rdata;
	end

endmodule

`default_nettype wire

// ==== verification/pscr_properties.sv ====
// Purpose: port checker of the shed config bank
// Assumes: single clock, sync reset
// Notes: keeps own copies of latch a and hysteresis
`timescale 1ns/10ps
`default_nettype none
module pscr_props (
	input wire clk,
	input wire sys_rst,
	input wire en_pin,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire switching_rate_source,
	input wire droop_line_source,
	input wire overcurrent_limit_source,
	input wire shed_threshold_source,
	input wire [2:0] phase_count
);
	logic en_q; // enable one cycle ago
	logic [7:0] la; // latch a copy
	logic [7:0] hy; // hysteresis copy
	wire chg = en_pin != en_q; // enable toggled
	wire [3:0] src = {switching_rate_source, droop_line_source,
		overcurrent_limit_source, shed_threshold_source};
	wire [3:0] wsel = {reg_wdata[5], reg_wdata[4], reg_wdata[2],
		reg_wdata[0]};
	// a toggle of enable beats a latch write in the same cycle
	always @(posedge clk)
	begin
		en_q <= sys_rst ? 1'b0 : en_pin;
		if (sys_rst || chg)
			la <= 8'h00;
		else if (reg_wr && reg_addr == 8'h46)
			la <= reg_wdata & 8'h35;
		if (sys_rst)
			hy <= 8'h00;
		else if (reg_wr && reg_addr == 8'h44)
			hy <= reg_wdata;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	property p_en_clear;
		$changed(en_pin) |-> ##2 src == 4'h0;
	endproperty
	a_en_clear: assert property (p_en_clear)
		else $error("source kept after enable change");
	property p_commit;
		reg_wr && reg_addr == 8'h47 && !chg && (reg_wdata & 8'h35) == la
			|-> ##2 src == $past(wsel, 2);
	endproperty
	a_commit: assert property (p_commit)
		else $error("matching byte not applied");
	property p_keep;
		reg_wr && reg_addr == 8'h47 && !chg && (reg_wdata & 8'h35) != la
			|-> ##2 src == $past(src, 2);
	endproperty
	a_keep: assert property (p_keep)
		else $error("mismatched byte changed sources");
	property p_src_cause;
		$changed(src) |-> $past(reg_wr, 2) || $past(chg, 2)
			|| $past(sys_rst);
	endproperty
	a_src_cause: assert property (p_src_cause)
		else $error("sources moved without cause");
	property p_hyst_rd;
		reg_rd && !reg_wr && reg_addr == 8'h44 |=> reg_rdata == hy;
	endproperty
	a_hyst_rd: assert property (p_hyst_rd)
		else $error("hysteresis readback wrong");
	property p_unmapped;
		reg_rd && reg_addr == 8'h42 |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	property p_rd_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without read");
	property p_phase;
		phase_count >= 3'd1 && phase_count <= 3'd4;
	endproperty
	a_phase: assert property (p_phase)
		else $error("phase count out of range");
endmodule
bind pscr_top pscr_props u_props (.clk, .sys_rst, .en_pin, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .switching_rate_source,
	.droop_line_source, .overcurrent_limit_source, .shed_threshold_source,
	.phase_count);
`default_nettype wire

// ==== verification/pscr_host.sv ====
// Purpose: host model on the register port
// Assumes: the bank takes strobes on the rising clock
// Notes: released lines carry inverted values
`timescale 1ns/10ps
`default_nettype none
module pscr_host (
	input wire clk,
	input wire [7:0] reg_rdata,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] reg_wdata = 8'h00,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0
);
	// one strobe edge per write
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// data is taken one edge after the strobe edge
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge clk);
		d = reg_rdata;
	endtask
	// same byte to both halves, caller picks the order
	task sel(input logic [7:0] b, input logic b_first);
		wr(b_first ? 8'h47 : 8'h46, b);
		wr(b_first ? 8'h46 : 8'h47, b);
	endtask
endmodule
`default_nettype wire

// ==== verification/tb_phase_shed_config_regs.sv ====
// Purpose: self-checking bench of the shed config bank
// Assumes: host model owns the register port
// Notes: a short delay step keeps shedding waits brief
`timescale 1ns/10ps
`default_nettype none
module tb_phase_shed_config_regs;
	logic clk = 1'b0;
	logic sys_rst = 1'b1; // held for 20 cycles
	logic en_pin = 1'b0;
	logic [31:0] strap_code = 32'h0;
	logic [3:0] strap_over_2v = 4'h0;
	logic [7:0] cur = 8'h00; // current reading code
	logic [1:0] dr = 2'd0; // droop code, strap gets its inverse
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire reg_wr, reg_rd;
	wire [3:0] s; // switching, droop, overcurrent, threshold
	wire [6:0] pct;
	wire [2:0] ph;
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int i;
	logic [7:0] a, d;
	logic [7:0] pcts [4] = '{8'd100, 8'd50, 8'd25, 8'd0};
	always #10 clk = ~clk;
	pscr_host u_host (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd);
	pscr_top #(.STEP_CYC(5)) dut_u (.clk, .sys_rst, .en_pin, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .strap_code,
		.strap_over_2v, .output_current_reading(cur),
		.droop_reg_code(dr), .droop_strap_code(~dr),
		.switching_rate_source(s[3]), .droop_line_source(s[2]),
		.overcurrent_limit_source(s[1]), .shed_threshold_source(s[0]),
		.droop_fraction_pct(pct), .phase_count(ph));
	task chk(input string n, input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// expected read after reset, or after writing offset ^ c3
	function automatic logic [7:0] ev(input logic [7:0] a, input logic w);
		logic [7:0] v;
		v = w ? a ^ 8'hc3 : 8'h00;
		if (a < 8'h42 && a[0])
			return 8'hff; // status stays disabled until an enable rise
		if (a == 8'h42 || a == 8'h43)
			return 8'h00;
		if (a < 8'h42)
			return w ? v : 8'hff;
		if (a == 8'h45)
			return w ? v : 8'h14;
		return a > 8'h45 ? v & 8'h35 : v;
	endfunction
	// a hang ends the run as a failure
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			print_verdict;
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		// reset values, then a pattern written and read at every offset
		for (i = 0; i < 28; i++)
		begin
			a = 8'h3a + 8'(i % 14);
			if (i > 13)
				u_host.wr(a, a ^ 8'hc3);
			u_host.rd(a, d);
			chk("reg", d, ev(a, i > 13));
		end
		chk("src", {4'h0, s}, 8'h00);
		// latch bits 0 to 5 alone, reserved 1 and 3 too, then all ones, in both orders
		for (i = 0; i < 7; i++)
		begin
			d = i < 6 ? 8'h01 << i : 8'hff;
			u_host.sel(d, i[0]);
			repeat (2) @(posedge clk);
			chk("src", {4'h0, s}, {4'h0, d[5], d[4], d[2], d[0]});
			u_host.rd(8'h47, a);
			chk("latch", a, d & 8'h35);
		end
		u_host.wr(8'h46, 8'h00);
		repeat (2) @(posedge clk);
		chk("keep", {4'h0, s}, 8'h0f);
		for (i = 0; i < 4; i++)
		begin
			dr <= i[1:0];
			repeat (3) @(posedge clk);
			chk("droop", {1'b0, pct}, pcts[i]);
		end
		// enable rise reloads status and hands control to straps
		strap_code <= 32'h10106040;
		strap_over_2v <= 4'hc;
		@(posedge clk);
		en_pin <= 1'b1;
		repeat (4) @(posedge clk);
		chk("en", {4'h0, s}, 8'h00);
		chk("strap droop", {1'b0, pct}, 8'd100);
		for (i = 0; i < 4; i++)
		begin
			u_host.rd(8'h3b + 8'(2 * i), d);
			chk("stat", d, i < 2 ? 8'h40 + 8'(32 * i) : 8'hff);
		end
		// strap thresholds: only 0x40 is reachable
		u_host.wr(8'h44, 8'h08);
		u_host.wr(8'h45, 8'h02);
		cur <= 8'h50;
		repeat (5) @(posedge clk);
		chk("up", {5'h0, ph}, 8'h02);
		cur <= 8'h3c;
		repeat (40) @(posedge clk);
		chk("hyst", {5'h0, ph}, 8'h02);
		cur <= 8'h37;
		repeat (6) @(posedge clk);
		chk("wait", {5'h0, ph}, 8'h02);
		repeat (20) @(posedge clk);
		chk("drop", {5'h0, ph}, 8'h01);
		// register thresholds given as current reading codes
		for (i = 0; i < 4; i++)
			u_host.wr(8'h3a + 8'(2 * i), i < 2 ? 8'h20 + 8'(16 * i) : 8'hff);
		u_host.sel(8'h01, 1'b0);
		cur <= 8'h30;
		repeat (6) @(posedge clk);
		chk("reg thr", {5'h0, ph}, 8'h03);
		u_host.wr(8'h3c, 8'hff);
		// disabling acts at once, well before a shed delay could run out
		repeat (3) @(posedge clk);
		chk("off", {5'h0, ph}, 8'h02);
		print_verdict;
	end
endmodule
`default_nettype wire
